/* logic/ttc_top.sv */
// thermal throttle controller: operating point sequencer, clock gating, hot pin
// Operation
// RULE1: raise voltage fully before frequency goes up
// RULE2: lower frequency fully before voltage goes down
// RULE3: stall execution only during frequency changes
// RULE4: below trigger, return to normal operating point
// RULE5: faster software request waits until event ends
// RULE6: slower software request applies at once
// RULE7: gating only when hot and at minimum
// RULE8: gating duty fixed at one quarter on
// RULE9: gating period 32 us from fixed timebase
// RULE10: stop only when cool and hysteresis expired
// RULE11: snoops and interrupts keep running while throttled
// RULE12: averaged loop adjusts frequency, never gates
// RULE13: instantaneous sensor read, averaged hottest report
// RULE14: readings are saturating distance below maximum
// RULE15: activation at zero distance unless offset set
// RULE16: two thresholds raise crossing interrupts
// RULE17: hot output whenever any sensor activates
// RULE18: hot pin input only until bidirectional set
// RULE19: external hot forces lowest state, no gating
// RULE20: optional interrupt on hot pin edges
// RULE21: own drive masks external hot sensing
// RULE22: external hot response within 100 us
// RULE23: activation equals maximum minus six-bit offset
// RULE24: external hot overrides adaptive sequence
`timescale 1ns/1ps
`include "ttc_map.svh"
module ttc_top #(
   parameter int N_SENS         = 4,
   parameter int STEP_CYC       = `TTC_STEP_CYC,
   parameter int AVG_SAMPLE_CYC = `TTC_AVG_SAMPLE_CYC
) (
   input  wire logic                       mclk,
   input  wire logic                       resetn,
   input  wire logic [N_SENS*8-1:0]        sensor_raw,
   input  wire logic [7:0]                 max_junction_temp,
   input  wire logic [5:0]                 act_offset,
   input  wire logic                       avg_loop_en,
   input  wire logic [1:0]                 sensor_sel,
   input  wire logic [7:0]                 thresh1,
   input  wire logic [7:0]                 thresh2,
   input  wire logic                       thresh_int_en,
   input  wire logic                       hot_bidir_en,
   input  wire logic                       hot_int_en,
   input  wire logic                       sw_req,
   input  wire logic [7:0]                 sw_ratio,
   input  wire logic                       volt_ack,
   input  wire logic                       freq_ack,
   input  wire logic                       package_hot_pin_n_in,
   output logic                            package_hot_pin_n_out,
   output logic                            package_hot_pin_n_oe,
   output logic [7:0]                      volt_code,
   output logic                            volt_req,
   output logic [7:0]                      freq_ratio,
   output logic                            freq_req,
   output logic                            exec_stall,
   output logic                            clk_gate_off,
   output logic                            throttle_active,
   output logic                            hot_status,
   output logic                            sw_pending,
   output logic [7:0]                      inst_temp,
   output logic [7:0]                      avg_temp,
   output logic                            thresh_irq,
   output logic                            hot_pin_irq
);
   localparam logic [7:0] RMAX = `TTC_RATIO_MAX;
   localparam logic [7:0] RMIN = `TTC_RATIO_MIN;

   function automatic logic [7:0] dist_of(input logic [7:0] tmax, input logic [7:0] raw);
      dist_of = (raw >= tmax) ? 8'h00 : 8'(tmax - raw); // RULE14
   endfunction : dist_of

   function automatic logic [7:0] volt_of(input logic [7:0] r);
      volt_of = 8'(`TTC_VID_BASE + r);
   endfunction : volt_of

   function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
      min8 = (a < b) ? a : b;
   endfunction : min8

   // hottest sensor and activation
   logic [7:0] hot_min;
   logic       any_hot;
   always_comb begin
      hot_min = 8'hFF;
      any_hot = 1'b0;
      for (int i = 0; i < N_SENS; i++) begin
         if (dist_of(max_junction_temp, sensor_raw[i*8+:8]) < hot_min) begin
            hot_min = dist_of(max_junction_temp, sensor_raw[i*8+:8]);
         end
         if (dist_of(max_junction_temp, sensor_raw[i*8+:8]) <= {2'h0, act_offset}) begin
            any_hot = 1'b1; // RULE15 RULE23
         end
      end
   end

   logic [7:0] sel_dist;
   assign sel_dist = dist_of(max_junction_temp, sensor_raw[sensor_sel*8+:8]);

   // hot pin: drive only when bidirectional and hot, sense only when not driving
   logic ext_hot_r;
   logic ext_hot_nxt;
   assign ext_hot_nxt = !package_hot_pin_n_in && !package_hot_pin_n_oe; // RULE21
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ext_hot_r             <= 1'b0;
         package_hot_pin_n_oe  <= 1'b0;
         package_hot_pin_n_out <= 1'b1;
         hot_status            <= 1'b0;
         hot_pin_irq           <= 1'b0;
      end else begin
         ext_hot_r             <= ext_hot_nxt;
         package_hot_pin_n_oe  <= hot_bidir_en && any_hot; // RULE18
         package_hot_pin_n_out <= 1'b0;
         hot_status            <= any_hot; // RULE17
         hot_pin_irq           <= hot_int_en && (ext_hot_nxt != ext_hot_r); // RULE20
      end
   end

   // thresholds
   logic [1:0] thr_r;
   logic [1:0] thr_nxt;
   assign thr_nxt = {hot_min <= thresh2, hot_min <= thresh1};
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         thr_r      <= 2'h0;
         thresh_irq <= 1'b0;
      end else begin
         thr_r      <= thr_nxt;
         thresh_irq <= thresh_int_en && (thr_nxt != thr_r); // RULE16
      end
   end

   // step timebase, hysteresis and throttle state
   logic [31:0] step_cnt_r;
   logic [31:0] hyst_cnt_r;
   logic        step_tick;
   assign step_tick = (step_cnt_r == 32'(STEP_CYC - 1));
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         step_cnt_r      <= 32'h0;
         hyst_cnt_r      <= 32'h0;
         throttle_active <= 1'b0;
      end else begin
         step_cnt_r <= step_tick ? 32'h0 : step_cnt_r + 32'h1;
         if (any_hot) begin
            throttle_active <= 1'b1;
            hyst_cnt_r      <= 32'(`TTC_HYST_CYC);
         end else if (hyst_cnt_r != 32'h0) begin
            hyst_cnt_r <= hyst_cnt_r - 32'h1;
         end else begin
            throttle_active <= 1'b0; // RULE10
         end
      end
   end

   // thermal and averaged targets
   logic [7:0] therm_tgt_r;
   logic [7:0] avg_cap_r;
   logic [7:0] sw_ratio_r;
   logic       avg_hot;
   assign avg_hot = avg_loop_en && (avg_temp <= {2'h0, act_offset});
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         therm_tgt_r <= RMAX;
         avg_cap_r   <= RMAX;
         sw_ratio_r  <= RMAX;
      end else begin
         if (sw_req) begin
            sw_ratio_r <= sw_ratio;
         end
         if (!throttle_active) begin
            therm_tgt_r <= RMAX; // RULE4
         end else if (step_tick && therm_tgt_r > RMIN) begin
            therm_tgt_r <= therm_tgt_r - 8'h01;
         end
         if (step_tick && avg_hot && avg_cap_r > RMIN) begin
            avg_cap_r <= avg_cap_r - 8'h01; // RULE12
         end else if (step_tick && !avg_hot && avg_cap_r < RMAX) begin
            avg_cap_r <= avg_cap_r + 8'h01;
         end
      end
   end

   logic [7:0] tgt;
   logic [7:0] sw_eff;
   assign sw_eff = min8(sw_ratio_r, avg_cap_r);
   assign tgt = ext_hot_r ? RMIN : // RULE19 RULE24 RULE22
                throttle_active ? min8(sw_eff, therm_tgt_r) : sw_eff; // RULE5 RULE6
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sw_pending <= 1'b0;
      end else begin
         sw_pending <= throttle_active && (sw_ratio_r > therm_tgt_r);
      end
   end

   // operating point sequencer
   ttc_pkg::ttc_seq_t st_r;
   logic [7:0]        cur_r;
   logic [7:0]        pend_r;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_r       <= ttc_pkg::S_IDLE;
         cur_r      <= RMAX;
         pend_r     <= RMAX;
         volt_code  <= volt_of(RMAX);
         volt_req   <= 1'b0;
         freq_ratio <= RMAX;
         freq_req   <= 1'b0;
         exec_stall <= 1'b0;
      end else begin
         case (st_r)
            ttc_pkg::S_IDLE: begin
               pend_r <= tgt;
               if (tgt > cur_r) begin
                  volt_code <= volt_of(tgt);
                  volt_req  <= 1'b1;
                  st_r      <= ttc_pkg::S_VUP;
               end else if (tgt < cur_r) begin
                  freq_ratio <= tgt;
                  freq_req   <= 1'b1;
                  exec_stall <= 1'b1; // RULE3
                  st_r       <= ttc_pkg::S_FDN;
               end
            end
            ttc_pkg::S_VUP: begin
               if (volt_ack) begin
                  volt_req   <= 1'b0;
                  freq_ratio <= pend_r;
                  freq_req   <= 1'b1; // RULE1
                  exec_stall <= 1'b1;
                  st_r       <= ttc_pkg::S_FUP;
               end
            end
            ttc_pkg::S_FUP: begin
               if (freq_ack) begin
                  freq_req   <= 1'b0;
                  exec_stall <= 1'b0; // RULE11
                  cur_r      <= pend_r;
                  st_r       <= ttc_pkg::S_IDLE;
               end
            end
            ttc_pkg::S_FDN: begin
               if (freq_ack) begin
                  freq_req   <= 1'b0;
                  exec_stall <= 1'b0;
                  volt_code  <= volt_of(pend_r);
                  volt_req   <= 1'b1; // RULE2
                  st_r       <= ttc_pkg::S_VDN;
               end
            end
            ttc_pkg::S_VDN: begin
               if (volt_ack) begin
                  volt_req <= 1'b0;
                  cur_r    <= pend_r;
                  st_r     <= ttc_pkg::S_IDLE;
               end
            end
            default: st_r <= ttc_pkg::S_IDLE;
         endcase
      end
   end

   // fixed duty clock gating
   logic [11:0] gate_cnt_r;
   logic        gate_en;
   assign gate_en = throttle_active && any_hot && therm_tgt_r == RMIN && cur_r == RMIN && !ext_hot_r; // RULE7 RULE24
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         gate_cnt_r   <= 12'h000;
         clk_gate_off <= 1'b0;
      end else if (!gate_en) begin
         gate_cnt_r   <= 12'h000;
         clk_gate_off <= 1'b0;
      end else begin
         gate_cnt_r   <= (gate_cnt_r == 12'(`TTC_GATE_CYC - 1)) ? 12'h000 : gate_cnt_r + 12'h001; // RULE9
         clk_gate_off <= (gate_cnt_r >= 12'(`TTC_GATE_ON_CYC - 1)) &&
                         (gate_cnt_r != 12'(`TTC_GATE_CYC - 1)); // RULE8
      end
   end

   // instantaneous read and averaged hottest report
   logic [31:0] samp_cnt_r;
   logic [15:0] acc_r;
   logic [7:0]  nsamp_r;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         samp_cnt_r <= 32'h0;
         acc_r      <= 16'h0000;
         nsamp_r    <= 8'h00;
         inst_temp  <= 8'h00;
         avg_temp   <= 8'hFF;
      end else begin
         inst_temp <= sel_dist; // RULE13
         if (samp_cnt_r == 32'(AVG_SAMPLE_CYC - 1)) begin
            samp_cnt_r <= 32'h0;
            nsamp_r    <= nsamp_r + 8'h01;
            if (nsamp_r == 8'(`TTC_AVG_SAMPLES - 1)) begin
               avg_temp <= 8'((acc_r + {8'h00, hot_min}) >> `TTC_AVG_SHIFT); // RULE13
               acc_r    <= 16'h0000;
            end else begin
               acc_r <= acc_r + {8'h00, hot_min};
            end
         end else begin
            samp_cnt_r <= samp_cnt_r + 32'h1;
         end
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence seq_up_start;
      st_r == ttc_pkg::S_IDLE && tgt > cur_r ##1 st_r == ttc_pkg::S_VUP;
   endsequence
   sequence seq_dn_start;
      st_r == ttc_pkg::S_IDLE && tgt < cur_r ##1 st_r == ttc_pkg::S_FDN;
   endsequence

   a_up_volt_first: assert property (seq_up_start |-> volt_req && !freq_req) // RULE1
      else $error("frequency moved before voltage on raise");
   a_dn_freq_first: assert property (seq_dn_start |-> freq_req && !volt_req) // RULE2
      else $error("voltage moved before frequency on lower");
   a_stall_freq: assert property (exec_stall |-> (st_r == ttc_pkg::S_FUP || st_r == ttc_pkg::S_FDN)) // RULE3
      else $error("stall outside frequency change");
   a_sw_defer: assert property (throttle_active && !ext_hot_r |-> tgt <= therm_tgt_r && tgt <= sw_ratio_r) // RULE5
      else $error("software request above thermal target applied");
   a_gate_min: assert property (clk_gate_off |-> cur_r == RMIN && $past(!ext_hot_r)) // RULE7
      else $error("gating while not at minimum");
   a_gate_duty: assert property ($rose(clk_gate_off) |-> $past(gate_cnt_r) == 12'(`TTC_GATE_ON_CYC - 1)) // RULE8
      else $error("gating off phase starts at wrong point");
   a_gate_on_phase: assert property ($fell(clk_gate_off) && gate_en |=> !clk_gate_off [*8]) // RULE8
      else $error("on phase too short");
   a_cool_release: assert property (!any_hot && hyst_cnt_r != 32'h0 |=> throttle_active) // RULE10
      else $error("throttle released before hysteresis");
   a_ext_min: assert property (ext_hot_r |-> tgt == RMIN ##1 !clk_gate_off) // RULE19
      else $error("external hot did not force minimum");
   a_hot_flag: assert property (any_hot |=> hot_status) // RULE17
      else $error("hot output missing");
   a_pin_input: assert property (!$past(hot_bidir_en) |-> !package_hot_pin_n_oe) // RULE18
      else $error("hot pin driven while input only");
   a_sw_pend_flag: assert property (throttle_active && sw_ratio_r > therm_tgt_r |=> sw_pending) // RULE5
      else $error("deferred software request not flagged");
   a_avg_no_gate: assert property (!any_hot |=> !clk_gate_off) // RULE12
      else $error("gating without a hot sensor");
endmodule : ttc_top

/* logic/ttc_map.svh */
// offsets, reset values and timing counts of the thermal throttle controller
`ifndef TTC_MAP_SVH
`define TTC_MAP_SVH
`define TTC_CLK_NS          10
`define TTC_GATE_PERIOD_US  32
`define TTC_GATE_CYC        ((`TTC_GATE_PERIOD_US * 1000) / `TTC_CLK_NS)
`define TTC_GATE_ON_CYC     (`TTC_GATE_CYC / 4)
`define TTC_AVG_WIN_MS      256
`define TTC_AVG_SAMPLES     256
`define TTC_AVG_SHIFT       8
`define TTC_AVG_SAMPLE_CYC  ((`TTC_AVG_WIN_MS * 1000000 / `TTC_CLK_NS) / `TTC_AVG_SAMPLES)
`define TTC_STEP_US         1000
`define TTC_STEP_CYC        ((`TTC_STEP_US * 1000) / `TTC_CLK_NS)
`define TTC_HYST_US         32
`define TTC_HYST_CYC        ((`TTC_HYST_US * 1000) / `TTC_CLK_NS)
`define TTC_EXT_RESP_US     100
`define TTC_EXT_RESP_CYC    ((`TTC_EXT_RESP_US * 1000) / `TTC_CLK_NS)
`define TTC_RATIO_MAX       8'h20
`define TTC_RATIO_MIN       8'h08
`define TTC_VID_BASE        8'h10
`define TTC_TEMP_W          8
`define TTC_OFFSET_W        6
`endif

/* logic/ttc_pkg.sv */
// types of the thermal throttle controller
package ttc_pkg;
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_VUP  = 5'h02,
      S_FUP  = 5'h04,
      S_FDN  = 5'h08,
      S_VDN  = 5'h10
   } ttc_seq_t;
endpackage : ttc_pkg

/* tb/ttc_platform_model.sv */
// platform side of the hot pin plus voltage regulator and clock acknowledges
`timescale 1ns/1ps
module ttc_platform_model (
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       ext_assert,
   input  wire logic [3:0] ack_dly,
   input  wire logic       volt_req,
   input  wire logic       freq_req,
   input  wire logic       pin_n_out,
   input  wire logic       pin_n_oe,
   output logic            pin_n,
   output logic            volt_ack,
   output logic            freq_ack
);
   logic [3:0] vcnt_r;
   logic [3:0] fcnt_r;

   // open-drain wire with pull-up: low while either party pulls it
   assign pin_n = !(ext_assert || (pin_n_oe && !pin_n_out));

   // acknowledges come ack_dly+1 cycles after a request and last one cycle
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         vcnt_r   <= 4'h0;
         fcnt_r   <= 4'h0;
         volt_ack <= 1'b0;
         freq_ack <= 1'b0;
      end else begin
         vcnt_r   <= (volt_req && !volt_ack) ? vcnt_r + 4'h1 : 4'h0;
         fcnt_r   <= (freq_req && !freq_ack) ? fcnt_r + 4'h1 : 4'h0;
         volt_ack <= volt_req && !volt_ack && (vcnt_r >= ack_dly);
         freq_ack <= freq_req && !freq_ack && (fcnt_r >= ack_dly);
      end
   end
endmodule : ttc_platform_model

/* tb/ttc_top_test.sv */
// self-checking bench of the thermal throttle controller
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
`define WAIT(c, lim) begin for (int k = 0; k < (lim) && !(c); k++) @(negedge mclk); `CHK(c, 1'b1) end
module ttc_top_test;
   localparam logic [31:0] COOL = {8'h3C, 8'h46, 8'h5A, 8'h50};
   localparam logic [31:0] HOT  = {8'h3C, 8'h46, 8'h70, 8'h50};
   logic        mclk, resetn, avg_loop_en, thresh_int_en, hot_bidir_en, hot_int_en, sw_req, ext_assert;
   logic [31:0] sensor_raw;
   logic [7:0]  max_junction_temp, thresh1, thresh2, sw_ratio;
   logic [5:0]  act_offset;
   logic [1:0]  sensor_sel;
   logic [3:0]  ack_dly;
   logic        volt_ack, freq_ack, pin_n, pin_n_out, pin_n_oe, volt_req, freq_req, exec_stall;
   logic        clk_gate_off, throttle_active, hot_status, sw_pending, thresh_irq, hot_pin_irq;
   logic [7:0]  volt_code, freq_ratio, inst_temp, avg_temp;
   int          fail_count, checks_done, n;

   ttc_top #(.N_SENS(4), .STEP_CYC(8), .AVG_SAMPLE_CYC(4)) ttc_top_inst (
      .mclk(mclk), .resetn(resetn), .sensor_raw(sensor_raw), .max_junction_temp(max_junction_temp),
      .act_offset(act_offset), .avg_loop_en(avg_loop_en), .sensor_sel(sensor_sel), .thresh1(thresh1),
      .thresh2(thresh2), .thresh_int_en(thresh_int_en), .hot_bidir_en(hot_bidir_en), .hot_int_en(hot_int_en),
      .sw_req(sw_req), .sw_ratio(sw_ratio), .volt_ack(volt_ack), .freq_ack(freq_ack),
      .package_hot_pin_n_in(pin_n), .package_hot_pin_n_out(pin_n_out), .package_hot_pin_n_oe(pin_n_oe),
      .volt_code(volt_code), .volt_req(volt_req), .freq_ratio(freq_ratio), .freq_req(freq_req),
      .exec_stall(exec_stall), .clk_gate_off(clk_gate_off), .throttle_active(throttle_active),
      .hot_status(hot_status), .sw_pending(sw_pending), .inst_temp(inst_temp), .avg_temp(avg_temp),
      .thresh_irq(thresh_irq), .hot_pin_irq(hot_pin_irq));

   ttc_platform_model ttc_platform_model_inst (
      .mclk(mclk), .resetn(resetn), .ext_assert(ext_assert), .ack_dly(ack_dly), .volt_req(volt_req),
      .freq_req(freq_req), .pin_n_out(pin_n_out), .pin_n_oe(pin_n_oe), .pin_n(pin_n),
      .volt_ack(volt_ack), .freq_ack(freq_ack));

   always #5 mclk = ~mclk;

   task automatic complete_run();
      if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   task automatic pulse_sw(input logic [7:0] r);
      sw_ratio = r;
      sw_req = 1'b1;
      @(negedge mclk);
      sw_req = 1'b0;
   endtask : pulse_sw

   // counts cycles that the gating output stays at one level
   task automatic span(input logic lvl, output int cnt);
      cnt = 0;
      while (clk_gate_off === lvl && cnt < 3000) begin
         @(negedge mclk);
         cnt++;
      end
   endtask : span

   // operating point ordering, stall and gating checked every cycle
   always @(negedge mclk) begin
      if (resetn === 1'b1) begin
         `CHK(volt_code >= 8'h10 + freq_ratio, 1'b1)
         `CHK(exec_stall, freq_req)
         `CHK(!clk_gate_off || freq_ratio == 8'h08, 1'b1)
      end
   end

   initial begin
      repeat (60000) @(posedge mclk);
      fail_count++;
      complete_run();
   end

   initial begin
      mclk = 1'b0;
      resetn = 1'b0;
      sensor_raw = COOL;
      max_junction_temp = 8'h64;
      act_offset = 6'h00;
      avg_loop_en = 1'b0;
      sensor_sel = 2'h0;
      thresh1 = 8'h05;
      thresh2 = 8'h08;
      thresh_int_en = 1'b1;
      hot_bidir_en = 1'b0;
      hot_int_en = 1'b1;
      sw_req = 1'b0;
      sw_ratio = 8'h20;
      ext_assert = 1'b0;
      ack_dly = 4'h4;
      fail_count = 0;
      checks_done = 0;
      repeat (10) @(negedge mclk);
      `CHK(pin_n_oe, 1'b0)
      `CHK(freq_ratio, 8'h20)
      resetn = 1'b1;
      for (int i = 0; i < 4; i++) begin
         sensor_sel = i[1:0];
         repeat (2) @(negedge mclk);
         `CHK(inst_temp, 8'h64 - sensor_raw[i*8 +: 8])
      end
      `WAIT(avg_temp == 8'h0A, 1100)
      act_offset = 6'h0A;
      `WAIT(hot_status, 3)
      act_offset = 6'h00;
      `WAIT(!throttle_active, 4000)
      `WAIT(freq_ratio == 8'h20 && !freq_req && !volt_req, 500)
      // sensor above the maximum saturates to distance zero
      sensor_raw = HOT;
      sensor_sel = 2'h1;
      `WAIT(hot_status, 3)
      `CHK(inst_temp, 8'h00)
      `WAIT(thresh_irq, 5)
      `CHK(pin_n_oe, 1'b0)
      pulse_sw(8'h0C);
      `WAIT(freq_ratio == 8'h0C, 60)
      `CHK(sw_pending, 1'b0)
      `WAIT(clk_gate_off, 4000)
      span(1'b1, n);
      `CHK(n, 2400)
      span(1'b0, n);
      `CHK(n, 800)
      pulse_sw(8'h18);
      repeat (3) @(negedge mclk);
      `CHK(sw_pending, 1'b1)
      `CHK(freq_ratio, 8'h08)
      sensor_raw = COOL;
      repeat (3000) @(negedge mclk);
      `CHK(throttle_active, 1'b1)
      `WAIT(!throttle_active, 400)
      `WAIT(freq_ratio == 8'h18 && !sw_pending, 500)
      `CHK(clk_gate_off, 1'b0)
      // external hot while sensors are hot as well
      ack_dly = 4'h0;
      sensor_raw = HOT;
      ext_assert = 1'b1;
      `WAIT(hot_pin_irq, 4)
      `WAIT(freq_ratio == 8'h08, 10000)
      repeat (4000) begin
         @(negedge mclk);
         `CHK(clk_gate_off, 1'b0)
      end
      `CHK(freq_ratio, 8'h08)
      ext_assert = 1'b0;
      sensor_raw = COOL;
      `WAIT(hot_pin_irq, 4)
      `WAIT(!throttle_active, 4000)
      // own drive hides the external request until released
      hot_bidir_en = 1'b1;
      sensor_raw = HOT;
      `WAIT(pin_n_oe, 4)
      `CHK(pin_n, 1'b0)
      ext_assert = 1'b1;
      repeat (20) begin
         @(negedge mclk);
         `CHK(hot_pin_irq, 1'b0)
      end
      sensor_raw = COOL;
      `WAIT(hot_pin_irq, 10)
      ext_assert = 1'b0;
      `WAIT(hot_pin_irq, 10)
      complete_run();
   end
endmodule : ttc_top_test
